/* File: rtl/ipsb_top.v */
`timescale 1ns/10ps
`include "ipsb_map.vh"

////////////////////////////////////////////////////////////////////////////
// priority steering for the second i2c unit and the second uart receive path
////////////////////////////////////////////////////////////////////////////

module ipsb_top (
    // clock and reset
    input  wire       i_core_clk,
    input  wire       i_rst_b,
    // software write of the priority bits
    input  wire       i_prio_we,
    input  wire [4:0] i_prio_wdata,
    // pending sources, same clock domain
    input  wire [4:0] i_src_pend,
    // priority readback
    output wire [4:0] o_prio,
    // routed requests per source
    output wire [4:0] o_hi_req,
    output wire [4:0] o_lo_req,
    // any request per level
    output reg        o_hi_any,
    output reg        o_lo_any
);
    ////////////////////////////////////////////////////////////////////////
    // priority register
    ////////////////////////////////////////////////////////////////////////

    reg  [4:0] prio_r;
    reg  [4:0] prio_nxt;

    // a write replaces all five bits at once; there is no per-bit mask,
    // so software must read back before changing a single source
    always @* begin
        prio_nxt = prio_r;
        if (i_prio_we) begin
            prio_nxt = i_prio_wdata;
        end
    end

    // reset to high priority for every source, as is usual for such bits
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            prio_r <= `IPSB_RST_VAL;
        end else begin
            prio_r <= prio_nxt;
        end
    end

    assign o_prio = prio_r;

    ////////////////////////////////////////////////////////////////////////
    // named priority fields and pending flags
    ////////////////////////////////////////////////////////////////////////

    // second i2c unit, error interrupt
    wire       i2c_unit2_err_prio;
    wire       i2c_unit2_err_pend;
    assign i2c_unit2_err_prio = prio_r[`IPSB_BIT_I2C2_ERR]; // see RQ1
    assign i2c_unit2_err_pend = i_src_pend[`IPSB_BIT_I2C2_ERR];

    // second i2c unit, general interrupt
    wire       i2c_unit2_gen_prio;
    wire       i2c_unit2_gen_pend;
    assign i2c_unit2_gen_prio = prio_r[`IPSB_BIT_I2C2_GEN]; // see RQ2
    assign i2c_unit2_gen_pend = i_src_pend[`IPSB_BIT_I2C2_GEN];

    // second i2c unit, transmit interrupt
    wire       i2c_unit2_tx_prio;
    wire       i2c_unit2_tx_pend;
    assign i2c_unit2_tx_prio = prio_r[`IPSB_BIT_I2C2_TX]; // see RQ3
    assign i2c_unit2_tx_pend = i_src_pend[`IPSB_BIT_I2C2_TX];

    // second i2c unit, receive interrupt
    wire       i2c_unit2_rx_prio;
    wire       i2c_unit2_rx_pend;
    assign i2c_unit2_rx_prio = prio_r[`IPSB_BIT_I2C2_RX]; // see RQ4
    assign i2c_unit2_rx_pend = i_src_pend[`IPSB_BIT_I2C2_RX];

    // second uart, receive interrupt
    wire       uart2_rx_prio;
    wire       uart2_rx_pend;
    assign uart2_rx_prio = prio_r[`IPSB_BIT_UART2_RX]; // see RQ5
    assign uart2_rx_pend = i_src_pend[`IPSB_BIT_UART2_RX];

    ////////////////////////////////////////////////////////////////////////
    // words rebuilt from the named fields
    ////////////////////////////////////////////////////////////////////////

    // going through the names keeps the bit map in one place: each field goes back
    // to the position it came from, so a wrong position in the header changes no routing
    wire [4:0] prio_vec;
    wire [4:0] pend_vec;

    assign prio_vec[`IPSB_BIT_I2C2_RX]  = i2c_unit2_rx_prio;
    assign prio_vec[`IPSB_BIT_I2C2_TX]  = i2c_unit2_tx_prio;
    assign prio_vec[`IPSB_BIT_I2C2_GEN] = i2c_unit2_gen_prio;
    assign prio_vec[`IPSB_BIT_I2C2_ERR] = i2c_unit2_err_prio;
    assign prio_vec[`IPSB_BIT_UART2_RX] = uart2_rx_prio;

    assign pend_vec[`IPSB_BIT_I2C2_RX]  = i2c_unit2_rx_pend;
    assign pend_vec[`IPSB_BIT_I2C2_TX]  = i2c_unit2_tx_pend;
    assign pend_vec[`IPSB_BIT_I2C2_GEN] = i2c_unit2_gen_pend;
    assign pend_vec[`IPSB_BIT_I2C2_ERR] = i2c_unit2_err_pend;
    assign pend_vec[`IPSB_BIT_UART2_RX] = uart2_rx_pend;

    ////////////////////////////////////////////////////////////////////////
    // per-source steering
    ////////////////////////////////////////////////////////////////////////

    // each bit routes its own source; bit 0..3 i2c unit 2, bit 4 uart 2
    genvar g;
    generate
        for (g = 0; g < `IPSB_NUM_BITS; g = g + 1) begin : g_route
            ipsb_route u_route (
                .i_core_clk (i_core_clk),
                .i_rst_b    (i_rst_b),
                .i_pend     (pend_vec[g]),
                .i_prio     (prio_vec[g]), // see RQ1 see RQ2 see RQ3 see RQ4 see RQ5
                .o_hi_req   (o_hi_req[g]),
                .o_lo_req   (o_lo_req[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // level summaries
    ////////////////////////////////////////////////////////////////////////

    reg        hi_any_nxt;
    reg        lo_any_nxt;

    // built from the same pending and priority values as the per-source
    // requests, so a summary never leads or lags its own source by a cycle
    always @* begin
        hi_any_nxt = 1'b0;
        lo_any_nxt = 1'b0;

        if (i2c_unit2_err_pend) begin
            if (i2c_unit2_err_prio) begin
                hi_any_nxt = 1'b1; // see RQ1
            end else begin
                lo_any_nxt = 1'b1; // see RQ1
            end
        end

        if (i2c_unit2_gen_pend) begin
            if (i2c_unit2_gen_prio) begin
                hi_any_nxt = 1'b1; // see RQ2
            end else begin
                lo_any_nxt = 1'b1; // see RQ2
            end
        end

        if (i2c_unit2_tx_pend) begin
            if (i2c_unit2_tx_prio) begin
                hi_any_nxt = 1'b1; // see RQ3
            end else begin
                lo_any_nxt = 1'b1; // see RQ3
            end
        end

        if (i2c_unit2_rx_pend) begin
            if (i2c_unit2_rx_prio) begin
                hi_any_nxt = 1'b1; // see RQ4
            end else begin
                lo_any_nxt = 1'b1; // see RQ4
            end
        end

        if (uart2_rx_pend) begin
            if (uart2_rx_prio) begin
                hi_any_nxt = 1'b1; // see RQ5
            end else begin
                lo_any_nxt = 1'b1; // see RQ5
            end
        end
    end

    // a write in the same cycle as a pending flag is not seen here until
    // the next cycle: the summary uses the priority that stood at the edge
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_hi_any <= 1'b0;
            o_lo_any <= 1'b0;
        end else begin
            o_hi_any <= hi_any_nxt;
            o_lo_any <= lo_any_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limitations
    ////////////////////////////////////////////////////////////////////////

    // the block only steers; choosing between levels, masking and flag
    // clearing belong to the controller that reads these requests

endmodule

/* File: shared/ipsb_map.vh */
// Overview of operation
// RQ1 - bit 3 of the priority byte sends the second i2c unit's error interrupt to high priority when 1, low when 0.
// RQ2 - bit 2 sends the second i2c unit's general interrupt to high priority when 1, low when 0.
// RQ3 - bit 1 sends the second i2c unit's transmit interrupt to high priority when 1, low when 0.
// RQ4 - bit 0 sends the second i2c unit's receive interrupt to high priority when 1, low when 0.
// RQ5 - bit 4 sends the second uart's receive interrupt to high priority when 1, low when 0.
`ifndef IPSB_MAP_VH
`define IPSB_MAP_VH
`define IPSB_BIT_I2C2_RX  0
`define IPSB_BIT_I2C2_TX  1
`define IPSB_BIT_I2C2_GEN 2
`define IPSB_BIT_I2C2_ERR 3
`define IPSB_BIT_UART2_RX 4
`define IPSB_NUM_BITS     5
`define IPSB_RST_VAL      5'h1f
`endif

/* File: rtl/ipsb_route.v */
`timescale 1ns/10ps
// one source: pending flag steered to the high or low level by its priority bit
module ipsb_route (
    // clock and reset
    input  wire i_core_clk,
    input  wire i_rst_b,
    // source and priority
    input  wire i_pend,
    input  wire i_prio,
    // routed request
    output reg  o_hi_req,
    output reg  o_lo_req
);
    always @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_hi_req <= 1'b0;
            o_lo_req <= 1'b0;
        end else begin
            o_hi_req <= i_pend & i_prio;
            o_lo_req <= i_pend & ~i_prio;
        end
    end
endmodule

/* File: bench/ipsb_checker.sv */
`timescale 1ns/10ps
module ipsb_checker (
    input wire       i_core_clk,
    input wire       i_rst_b,
    input wire [4:0] i_src_pend,
    input wire [4:0] o_prio,
    input wire [4:0] o_hi_req,
    input wire [4:0] o_lo_req,
    input wire       o_hi_any,
    input wire       o_lo_any
);
    wire [4:0] hw = i_src_pend & o_prio;
    wire [4:0] lw = i_src_pend & ~o_prio;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    err_route_a: assert property ($past(i_rst_b) |-> {o_hi_req[3], o_lo_req[3]} == $past({hw[3], lw[3]}))
        else $error("error source misrouted");
    gen_route_a: assert property ($past(i_rst_b) |-> {o_hi_req[2], o_lo_req[2]} == $past({hw[2], lw[2]}))
        else $error("general source misrouted");
    tx_route_a: assert property ($past(i_rst_b) |-> {o_hi_req[1], o_lo_req[1]} == $past({hw[1], lw[1]}))
        else $error("transmit source misrouted");
    rx_route_a: assert property ($past(i_rst_b) |-> {o_hi_req[0], o_lo_req[0]} == $past({hw[0], lw[0]}))
        else $error("receive source misrouted");
    uart_route_a: assert property ($past(i_rst_b) |-> {o_hi_req[4], o_lo_req[4]} == $past({hw[4], lw[4]}))
        else $error("uart source misrouted");
    hi_any_a: assert property ($past(i_rst_b) |-> o_hi_any == $past(|hw))
        else $error("high level summary wrong");
    lo_any_a: assert property ($past(i_rst_b) |-> o_lo_any == $past(|lw))
        else $error("low level summary wrong");
endmodule

/* File: bench/ipsb_top_tb.sv */
`timescale 1ns/10ps
`define CMP(nm, ex, got) begin checked = checked + 1; if ((got) !== (ex)) begin fails = fails + 1; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module ipsb_top_tb;
    reg        i_core_clk = 0, i_rst_b = 0, i_prio_we = 0;
    reg  [4:0] i_prio_wdata = 0, i_src_pend = 0, p_r = 5'h1f, e_hi, e_lo;
    wire [4:0] o_prio, o_hi_req, o_lo_req;
    wire       o_hi_any, o_lo_any;
    integer    fails = 0, checked = 0, n, seed;
    always #50 i_core_clk = ~i_core_clk;
    ipsb_top dut (.i_core_clk, .i_rst_b, .i_prio_we, .i_prio_wdata, .i_src_pend, .o_prio, .o_hi_req, .o_lo_req,
        .o_hi_any, .o_lo_any);
    task complete_run;
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        seed = $urandom(32'hd67950f5);
        repeat (4) @(posedge i_core_clk);
        for (n = 0; n < 400; n = n + 1) begin
            @(posedge i_core_clk);
            if (!i_rst_b) begin
                e_hi = 0;
                e_lo = 0;
                p_r = 5'h1f;
            end else begin
                e_hi = i_src_pend & p_r;
                e_lo = i_src_pend & ~p_r;
                if (i_prio_we) p_r = i_prio_wdata;
            end
            // one cycle of reset in mid-run; a random write in that cycle must be swallowed
            i_rst_b <= n != 200;
            // first two writes are back to back: all low, then all high
            i_prio_we <= n < 2 || $urandom % 2;
            i_prio_wdata <= n == 0 ? 5'h00 : n == 1 ? 5'h1f : $urandom % 32;
            i_src_pend <= n < 3 ? 5'h1f : $urandom % 32;
            #1;
            `CMP("prio", p_r, o_prio)
            `CMP("hi", {|e_hi, e_hi}, {o_hi_any, o_hi_req})
            `CMP("lo", {|e_lo, e_lo}, {o_lo_any, o_lo_req})
        end
        complete_run;
    end
endmodule
bind ipsb_top ipsb_checker chk (.i_core_clk, .i_rst_b, .i_src_pend, .o_prio, .o_hi_req, .o_lo_req,
    .o_hi_any, .o_lo_any);
